// ==== pkg/plc_timer_bank_defs.svh ====
`ifndef PLC_TIMER_BANK_DEFS_SVH
`define PLC_TIMER_BANK_DEFS_SVH

// Timing
`define CLK_PERIOD_NS    5
`define TICK_PERIOD_NS   1000000
`define TICK_CYCLES      (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_CNT_W       18
`define BASE_DIV         4'ha
`define BASE_DIV_W       4

// Timer bank geometry
`define NUM_TIMERS       256
`define IDX_W            8
`define CNT_W            16
`define CNT_MAX          16'h7fff
`define PEND_W           8
`define PEND_MAX         8'hff

// Register byte offsets
`define REG_CTRL         8'h00
`define REG_CMD          8'h04
`define REG_SEL          8'h08
`define REG_STATUS       8'h0c
`define REG_BITS0        8'h10
`define REG_BITS_END     8'h30

// Control register fields
`define CTRL_SCAN_BIT    0

// Command register fields
`define CMD_IDX_LSB      0
`define CMD_IDX_MSB      7
`define CMD_MODE_LSB     8
`define CMD_MODE_MSB     10
`define CMD_EN_BIT       11
`define CMD_REGION_BIT   12
`define CMD_RESET_BIT    13
`define CMD_PV_LSB       16
`define CMD_PV_MSB       31

// Status register fields
`define STAT_CNT_LSB     0
`define STAT_CNT_MSB     15
`define STAT_BIT_BIT     16
`define STAT_RUN_BIT     17
`define STAT_BASE_LSB    18
`define STAT_BASE_MSB    19
`define STAT_ACCUM_BIT   20

// Reset values
`define CMD_RESET_VAL    32'h0000_0000
`define SEL_RESET_VAL    8'h00

`endif

// ==== pkg/plc_timer_bank_pkg.sv ====
package plc_timer_bank_pkg;

  typedef enum logic [2:0] {
    on_delay_mode              = 3'h0,
    off_delay_mode             = 3'h1,
    std_on_delay_mode          = 3'h2,
    std_off_delay_mode         = 3'h3,
    pulse_mode                 = 3'h4,
    accumulating_on_delay_mode = 3'h5
  } timer_mode_t;

  typedef enum logic [1:0] {
    base_1ms   = 2'h0,
    base_10ms  = 2'h1,
    base_100ms = 2'h2
  } time_base_t;

  typedef struct packed {
    logic        en;
    logic        region_off;
    timer_mode_t mode;
    logic [15:0] preset_value;
  } timer_inputs_t;

  typedef struct packed {
    timer_inputs_t inp;
    logic          en_prev;
    logic          run;
    logic          tbit;
    logic [15:0]   cnt;
    logic [7:0]    pend;
  } timer_state_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [7:0]  sel;
    logic        scan;
    logic        exec;
    logic [31:0] cmd;
  } bus_state_t;

endpackage

// ==== rtl/tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "plc_timer_bank_defs.svh"

module tick_gen
  import plc_timer_bank_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output var  logic tick_1ms_o,
  output var  logic tick_10ms_o,
  output var  logic tick_100ms_o
);

  typedef struct packed {
    logic [`TICK_CNT_W-1:0] cyc;
    logic [`BASE_DIV_W-1:0] div10;
    logic [`BASE_DIV_W-1:0] div100;
    logic                   t1;
    logic                   t10;
    logic                   t100;
  } tick_state_t;

  tick_state_t st_r;
  tick_state_t st_nxt;

  localparam logic [`TICK_CNT_W-1:0] TICK_LAST = `TICK_CNT_W'(TICK_CYCLES - 1);
  localparam logic [`BASE_DIV_W-1:0] DIV_LAST  = `BASE_DIV - `BASE_DIV_W'(1);

  // Free running tick and decade dividers
  always_comb begin
    st_nxt      = st_r;
    st_nxt.t1   = 1'b0;
    st_nxt.t10  = 1'b0;
    st_nxt.t100 = 1'b0;
    if (st_r.cyc == TICK_LAST) begin
      st_nxt.cyc = '0;
      st_nxt.t1  = 1'b1;
      if (st_r.div10 == DIV_LAST) begin
        st_nxt.div10 = '0;
        st_nxt.t10   = 1'b1;
        if (st_r.div100 == DIV_LAST) begin
          st_nxt.div100 = '0;
          st_nxt.t100   = 1'b1;
        end else begin
          st_nxt.div100 = st_r.div100 + `BASE_DIV_W'(1);
        end
      end else begin
        st_nxt.div10 = st_r.div10 + `BASE_DIV_W'(1);
      end
    end else begin
      st_nxt.cyc = st_r.cyc + `TICK_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_1ms_o   = st_r.t1;
  assign tick_10ms_o  = st_r.t10;
  assign tick_100ms_o = st_r.t100;

endmodule
`default_nettype wire

// ==== rtl/timer_eval.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "plc_timer_bank_defs.svh"

module timer_eval
  import plc_timer_bank_pkg::*;
(
  input  wire logic         [8:0] delta_i,
  input  wire logic               rst_cmd_i,
  input  wire timer_state_t       st_i,
  output var  timer_state_t       st_o
);

  timer_state_t    s;
  logic     [16:0] sum;
  logic     [15:0] capped;
  logic     [15:0] to_pv;
  logic     [15:0] pv;
  logic            on;
  logic            fall;
  logic            rise;

  always_comb begin
    s      = st_i;
    pv     = st_i.inp.preset_value;
    on     = st_i.inp.en;
    fall   = st_i.en_prev & ~on;
    rise   = on & ~st_i.en_prev;
    sum    = {1'b0, st_i.cnt} + {8'h00, delta_i};
    capped = (sum > {1'b0, `CNT_MAX}) ? `CNT_MAX : sum[15:0];
    to_pv  = (capped >= pv) ? pv : capped;
    unique case (st_i.inp.mode)
      on_delay_mode: begin
        if (on) begin
          s.cnt  = capped;
          s.tbit = capped >= pv;
        end else begin
          s.cnt  = '0;
          s.tbit = 1'b0;
        end
      end
      accumulating_on_delay_mode: begin
        if (on) begin
          s.cnt  = capped;
          s.tbit = capped >= pv;
        end
      end
      off_delay_mode, std_off_delay_mode: begin
        if (st_i.inp.mode == off_delay_mode && st_i.inp.region_off) begin
          s.cnt  = '0;
          s.tbit = 1'b0;
          s.run  = 1'b0;
        end else if (on) begin
          s.tbit = 1'b1;
          s.cnt  = '0;
          s.run  = 1'b0;
        end else if (fall || st_i.run) begin
          s.cnt = to_pv;
          if (to_pv >= pv) begin
            s.tbit = 1'b0;
            s.run  = 1'b0;
          end else begin
            s.run = 1'b1;
          end
        end
      end
      std_on_delay_mode: begin
        if (on) begin
          s.cnt  = to_pv;
          s.tbit = to_pv >= pv;
        end else begin
          s.cnt  = '0;
          s.tbit = 1'b0;
        end
      end
      pulse_mode: begin
        if (st_i.run) begin
          s.cnt = to_pv;
          if (to_pv >= pv) begin
            s.tbit = 1'b0;
            s.run  = 1'b0;
          end
        end else if (rise) begin
          s.cnt  = '0;
          s.tbit = pv != '0;
          s.run  = pv != '0;
        end else if (!on) begin
          s.cnt = '0;
        end
      end
      default: begin
        s = st_i;
      end
    endcase
    s.en_prev = on;
    if (rst_cmd_i) begin
      s.cnt     = '0;
      s.tbit    = 1'b0;
      s.run     = 1'b0;
      s.en_prev = 1'b0;
    end
    st_o = s;
  end

endmodule
`default_nettype wire

// ==== rtl/plc_timer_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "plc_timer_bank_defs.svh"

module plc_timer_bank
  import plc_timer_bank_pkg::*;
#(
  parameter int   TICK_CYCLES  = `TICK_CYCLES,
  parameter logic RETAIN_ACCUM = 1'b0
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output var  logic [31:0]            wb_dat_o,
  output var  logic                   wb_ack_o,
  output var  logic [`NUM_TIMERS-1:0] timer_bits_o
);

  function automatic logic is_accum(input int idx);
    return (idx < 32) || (idx >= 64 && idx < 96);
  endfunction

  function automatic time_base_t base_of(input int idx);
    int low;
    low = idx % 32;
    if (idx >= 128) begin
      return base_100ms;
    end else if (low == 0) begin
      return base_1ms;
    end else if (low <= 4) begin
      return base_10ms;
    end else begin
      return base_100ms;
    end
  endfunction

  logic t1;
  logic t10;
  logic t100;

  tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .tick_1ms_o   (t1),
    .tick_10ms_o  (t10),
    .tick_100ms_o (t100)
  );

  bus_state_t   bus_r;
  bus_state_t   bus_nxt;
  timer_state_t tmr_r [`NUM_TIMERS];
  logic [31:0]  cmd_merged;
  logic [31:0]  rd_data;
  logic [31:0]  bits_word;
  logic [7:0]   bits_off;
  logic [`IDX_W-1:0] cmd_idx;
  timer_mode_t  cmd_mode;

  assign cmd_idx  = bus_r.cmd[`CMD_IDX_MSB:`CMD_IDX_LSB];
  assign cmd_mode = timer_mode_t'(bus_r.cmd[`CMD_MODE_MSB:`CMD_MODE_LSB]);
  assign bits_off = wb_adr_i - `REG_BITS0;

  // Byte lane merge into held command
  always_comb begin
    cmd_merged = bus_r.cmd;
    for (int b = 0; b < 4; b++) begin
      if (wb_sel_i[b]) begin
        cmd_merged[8*b +: 8] = wb_dat_i[8*b +: 8];
      end
    end
  end

  // One 32-bit slice of the timer bits
  always_comb begin
    bits_word = '0;
    for (int k = 0; k < 32; k++) begin
      bits_word[k] = tmr_r[{bits_off[4:2], 5'(k)}].tbit;
    end
  end

  // Read mux
  always_comb begin
    rd_data = '0;
    if (wb_adr_i >= `REG_BITS0 && wb_adr_i < `REG_BITS_END) begin
      rd_data = bits_word;
    end else begin
      unique case (wb_adr_i)
        `REG_CMD: begin
          rd_data = bus_r.cmd;
        end
        `REG_SEL: begin
          rd_data = {24'h000000, bus_r.sel};
        end
        `REG_STATUS: begin
          rd_data[`STAT_CNT_MSB:`STAT_CNT_LSB]   = tmr_r[bus_r.sel].cnt;
          rd_data[`STAT_BIT_BIT]                 = tmr_r[bus_r.sel].tbit;
          rd_data[`STAT_RUN_BIT]                 = tmr_r[bus_r.sel].run;
          rd_data[`STAT_BASE_MSB:`STAT_BASE_LSB] = base_of(int'(bus_r.sel));
          rd_data[`STAT_ACCUM_BIT]               = is_accum(int'(bus_r.sel));
        end
        default: begin
          rd_data = '0;
        end
      endcase
    end
  end

  // Wishbone classic slave, ack one cycle after the strobe
  always_comb begin
    bus_nxt      = bus_r;
    bus_nxt.ack  = 1'b0;
    bus_nxt.scan = 1'b0;
    bus_nxt.exec = 1'b0;
    if (wb_cyc_i && wb_stb_i && !bus_r.ack) begin
      bus_nxt.ack = 1'b1;
      bus_nxt.dat = wb_we_i ? 32'h0000_0000 : rd_data;
      if (wb_we_i) begin
        unique case (wb_adr_i)
          `REG_CTRL: begin
            bus_nxt.scan = wb_sel_i[0] & wb_dat_i[`CTRL_SCAN_BIT];
          end
          `REG_CMD: begin
            bus_nxt.cmd  = cmd_merged;
            bus_nxt.exec = 1'b1;
          end
          `REG_SEL: begin
            if (wb_sel_i[0]) begin
              bus_nxt.sel = wb_dat_i[7:0];
            end
          end
          default: begin
            bus_nxt.dat = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_r     <= '0;
      bus_r.cmd <= `CMD_RESET_VAL;
      bus_r.sel <= `SEL_RESET_VAL;
    end else begin
      bus_r <= bus_nxt;
    end
  end

  assign wb_ack_o = bus_r.ack;
  assign wb_dat_o = bus_r.dat;

  // Per-timer storage and update
  for (genvar i = 0; i < `NUM_TIMERS; i++) begin : g_tmr
    localparam time_base_t BASE  = base_of(i);
    localparam logic       ACCUM = is_accum(i);

    timer_state_t  cur;
    timer_state_t  ev_out;
    timer_state_t  tmr_nxt;
    timer_inputs_t in_nxt;
    logic          hit;
    logic          rst_cmd;
    logic          tick;
    logic          upd;
    logic [8:0]    delta;

    always_comb begin
      hit     = bus_r.exec && (cmd_idx == `IDX_W'(i));
      rst_cmd = hit && bus_r.cmd[`CMD_RESET_BIT];
      unique case (BASE)
        base_1ms:  tick = t1;
        base_10ms: tick = t10;
        default:   tick = t100;
      endcase
      in_nxt = tmr_r[i].inp;
      if (hit && !bus_r.cmd[`CMD_RESET_BIT]) begin
        in_nxt.en           = bus_r.cmd[`CMD_EN_BIT];
        in_nxt.region_off   = bus_r.cmd[`CMD_REGION_BIT];
        in_nxt.preset_value = bus_r.cmd[`CMD_PV_MSB:`CMD_PV_LSB];
        if (ACCUM) begin
          in_nxt.mode = accumulating_on_delay_mode;
        end else if (cmd_mode == accumulating_on_delay_mode || cmd_mode > pulse_mode) begin
          in_nxt.mode = on_delay_mode;
        end else begin
          in_nxt.mode = cmd_mode;
        end
      end
      unique case (BASE)
        base_1ms:  upd = tick | hit;
        base_10ms: upd = bus_r.scan | rst_cmd;
        default:   upd = hit;
      endcase
      delta   = rst_cmd ? 9'h000 : ({1'b0, tmr_r[i].pend} + {8'h00, tick});
      cur     = tmr_r[i];
      cur.inp = in_nxt;
      tmr_nxt = cur;
      if (upd) begin
        tmr_nxt      = ev_out;
        tmr_nxt.pend = '0;
      end else if (tick && tmr_r[i].pend != `PEND_MAX) begin
        tmr_nxt.pend = tmr_r[i].pend + `PEND_W'(1);
      end
    end

    timer_eval u_eval (
      .delta_i   (delta),
      .rst_cmd_i (rst_cmd),
      .st_i      (cur),
      .st_o      (ev_out)
    );

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        tmr_r[i] <= '0;
        if (ACCUM && RETAIN_ACCUM) begin
          tmr_r[i].cnt <= tmr_r[i].cnt;
        end
      end else begin
        tmr_r[i] <= tmr_nxt;
      end
    end

    assign timer_bits_o[i] = tmr_r[i].tbit;
  end

endmodule
`default_nettype wire

// ==== sim/plc_timer_bank_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "plc_timer_bank_defs.svh"

module plc_timer_bank_properties (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  input  wire logic [31:0]            wb_dat_o,
  input  wire logic                   wb_ack_o,
  input  wire logic [`NUM_TIMERS-1:0] timer_bits_o
);
  logic       wr_cmd;
  logic       slow;
  logic [2:0] md;
  logic [7:0] cmd_idx_r;

  // Index of the last command, held until the next one
  always_ff @(posedge clk_i) begin
    if (wr_cmd) begin
      cmd_idx_r <= wb_dat_i[7:0];
    end
  end

  assign wr_cmd = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h04
                  && wb_sel_i == 4'hf;
  assign slow   = wr_cmd && wb_dat_i[7:0] >= 8'd101 && !wb_dat_i[13];
  assign md     = wb_dat_i[10:8];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_first_scan;
    $fell(rst_i) |-> timer_bits_o == '0;
  endproperty
  a_first_scan: assert property (p_first_scan)
    else $error("timer bits not clear after reset");

  property p_reset_cmd;
    wr_cmd && wb_dat_i[13] |-> ##2 !timer_bits_o[$past(wb_dat_i[7:0], 2)];
  endproperty
  a_reset_cmd: assert property (p_reset_cmd)
    else $error("reset command left bit on");

  property p_on_off;
    slow && md == 3'h0 && !wb_dat_i[11] |-> ##2 !timer_bits_o[$past(wb_dat_i[7:0], 2)];
  endproperty
  a_on_off: assert property (p_on_off)
    else $error("disabled on-delay bit on");

  property p_on_reach;
    slow && md == 3'h0 && wb_dat_i[11] && wb_dat_i[31:16] == 16'h0
      |-> ##2 timer_bits_o[$past(wb_dat_i[7:0], 2)];
  endproperty
  a_on_reach: assert property (p_on_reach)
    else $error("on-delay at preset bit off");

  property p_off_en;
    slow && md == 3'h1 && wb_dat_i[11] && !wb_dat_i[12]
      |-> ##2 timer_bits_o[$past(wb_dat_i[7:0], 2)];
  endproperty
  a_off_en: assert property (p_off_en)
    else $error("enabled off-delay bit off");

  property p_off_region;
    slow && md == 3'h1 && wb_dat_i[12] |-> ##2 (!timer_bits_o[cmd_idx_r]) [*3];
  endproperty
  a_off_region: assert property (p_off_region)
    else $error("inactive region off-delay bit on");

  property p_off_steady;
    slow && md == 3'h1 && !wb_dat_i[11] && !wb_dat_i[12] && !timer_bits_o[wb_dat_i[7:0]]
      |-> ##2 !timer_bits_o[$past(wb_dat_i[7:0], 2)];
  endproperty
  a_off_steady: assert property (p_off_steady)
    else $error("steady off level started off-delay");

  property p_std_on;
    slow && md == 3'h2 && wb_dat_i[31:16] == 16'h0
      |-> ##2 timer_bits_o[$past(wb_dat_i[7:0], 2)] == $past(wb_dat_i[11], 2);
  endproperty
  a_std_on: assert property (p_std_on)
    else $error("standard on-delay output wrong");
endmodule
`default_nettype wire

// ==== sim/scan_engine_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module scan_engine_model (
  input  wire logic        clk_i,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic        wb_cyc_o,
  output var  logic        wb_stb_o,
  output var  logic        wb_we_o,
  output var  logic [7:0]  wb_adr_o,
  output var  logic [3:0]  wb_sel_o,
  output var  logic [31:0] wb_dat_o
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end

  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= a;
    wb_sel_o <= 4'hf;
    wb_dat_o <= d;
    repeat (50) begin
      @(posedge clk_i);
      if (wb_ack_i === 1'b1) break;
    end
    ok = (wb_ack_i === 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= 1'b0;
    wb_dat_o <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== sim/plc_timer_bank_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module plc_timer_bank_tb
  import plc_timer_bank_pkg::*;
;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]   wb_adr_i;
  logic [3:0]   wb_sel_i;
  logic [31:0]  wb_dat_i, wb_dat_o, q;
  logic [255:0] timer_bits_o;
  int           fail_count = 0;
  int           n_compared = 0;
  logic [7:0]   bi [13] = '{0, 1, 5, 32, 33, 37, 64, 68, 69, 96, 100, 101, 255};
  logic [2:0]   be [13] = '{4, 5, 6, 0, 1, 2, 4, 5, 6, 0, 1, 2, 2};

  always #2.5 clk_i = ~clk_i;

  plc_timer_bank #(.TICK_CYCLES(2)) u_plc_timer_bank (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_bits_o(timer_bits_o));

  scan_engine_model u_scan_engine_model (
    .clk_i(clk_i), .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i),
    .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i),
    .wb_dat_o(wb_dat_i));

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    u_scan_engine_model.xfer(we, a, d, q, ok);
    if (!ok) begin
      fail_count++;
      wrap_up();
    end
  endtask

  task automatic cmd(input logic [7:0] i, input timer_mode_t m, input logic en,
                     input logic rg, input logic rs, input logic [15:0] p);
    bus(1'b1, 8'h04, {p, 2'b00, rs, rg, en, m, i});
    idle(1);
  endtask

  task automatic st(input logic [7:0] i);
    bus(1'b1, 8'h08, {24'h0, i});
    bus(1'b0, 8'h0c, 32'h0);
  endtask

  task automatic sc(input logic [7:0] i, input logic [16:0] e);
    st(i);
    check({15'h0, q[16:0]}, {15'h0, e});
  endtask

  initial begin
    logic [16:0] v;
    int          k;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (k = 0; k < 8; k++) begin
      bus(1'b0, 8'h10 + 8'(4 * k), 32'h0);
      check(q, 32'h0);
    end
    $display("test reset done");
    for (k = 0; k < 13; k++) begin
      st(bi[k]);
      check({29'h0, q[20:18]}, {29'h0, be[k]});
    end
    $display("test bases done");
    cmd(8'd32, on_delay_mode, 1'b1, 1'b0, 1'b0, 16'h0005);
    idle(40);
    check({31'h0, timer_bits_o[32]}, 32'h1);
    cmd(8'd32, on_delay_mode, 1'b0, 1'b0, 1'b0, 16'h0005);
    sc(8'd32, 17'h0);
    cmd(8'd160, on_delay_mode, 1'b1, 1'b0, 1'b0, 16'h0);
    check({31'h0, timer_bits_o[160]}, 32'h1);
    cmd(8'd160, on_delay_mode, 1'b0, 1'b0, 1'b0, 16'h0);
    check({31'h0, timer_bits_o[160]}, 32'h0);
    cmd(8'd32, on_delay_mode, 1'b1, 1'b0, 1'b0, 16'h0005);
    idle(66000);
    sc(8'd32, 17'h17fff);
    bus(1'b0, 8'h14, 32'h0);
    check(q, 32'h0000_0001);
    $display("test on-delay done");
    cmd(8'd0, accumulating_on_delay_mode, 1'b1, 1'b0, 1'b0, 16'h0003);
    idle(20);
    cmd(8'd0, accumulating_on_delay_mode, 1'b0, 1'b0, 1'b0, 16'h0003);
    st(8'd0);
    v = q[16:0];
    idle(20);
    sc(8'd0, v);
    check({31'h0, v[16]}, 32'h1);
    cmd(8'd0, accumulating_on_delay_mode, 1'b1, 1'b0, 1'b0, 16'h0003);
    idle(20);
    st(8'd0);
    check({31'h0, q[15:0] > v[15:0]}, 32'h1);
    cmd(8'd0, accumulating_on_delay_mode, 1'b0, 1'b0, 1'b0, 16'h0003);
    cmd(8'd0, accumulating_on_delay_mode, 1'b0, 1'b0, 1'b1, 16'h0);
    sc(8'd0, 17'h0);
    $display("test accumulating done");
    cmd(8'd200, off_delay_mode, 1'b1, 1'b0, 1'b0, 16'h0002);
    sc(8'd200, 17'h10000);
    cmd(8'd200, off_delay_mode, 1'b0, 1'b0, 1'b0, 16'h0002);
    idle(100);
    cmd(8'd200, off_delay_mode, 1'b1, 1'b0, 1'b0, 16'h0002);
    sc(8'd200, 17'h10000);
    cmd(8'd200, off_delay_mode, 1'b0, 1'b0, 1'b0, 16'h0002);
    idle(450);
    cmd(8'd200, off_delay_mode, 1'b0, 1'b0, 1'b0, 16'h0002);
    sc(8'd200, 17'h00002);
    idle(450);
    cmd(8'd200, off_delay_mode, 1'b0, 1'b0, 1'b0, 16'h0002);
    sc(8'd200, 17'h00002);
    cmd(8'd200, off_delay_mode, 1'b0, 1'b0, 1'b1, 16'h0002);
    cmd(8'd200, off_delay_mode, 1'b0, 1'b0, 1'b0, 16'h0002);
    idle(450);
    cmd(8'd200, off_delay_mode, 1'b0, 1'b0, 1'b0, 16'h0002);
    sc(8'd200, 17'h0);
    cmd(8'd200, off_delay_mode, 1'b1, 1'b1, 1'b0, 16'h0002);
    sc(8'd200, 17'h0);
    $display("test off-delay done");
    cmd(8'd150, std_on_delay_mode, 1'b1, 1'b0, 1'b0, 16'h0);
    check({31'h0, timer_bits_o[150]}, 32'h1);
    cmd(8'd150, std_on_delay_mode, 1'b0, 1'b0, 1'b0, 16'h0);
    check({31'h0, timer_bits_o[150]}, 32'h0);
    cmd(8'd151, pulse_mode, 1'b1, 1'b0, 1'b0, 16'h0001);
    sc(8'd151, 17'h10000);
    idle(450);
    cmd(8'd151, pulse_mode, 1'b1, 1'b0, 1'b0, 16'h0001);
    sc(8'd151, 17'h00001);
    cmd(8'd152, std_off_delay_mode, 1'b1, 1'b0, 1'b0, 16'h0002);
    cmd(8'd152, std_off_delay_mode, 1'b0, 1'b0, 1'b0, 16'h0002);
    check({31'h0, timer_bits_o[152]}, 32'h1);
    idle(450);
    cmd(8'd152, std_off_delay_mode, 1'b0, 1'b0, 1'b0, 16'h0002);
    sc(8'd152, 17'h00002);
    $display("test standard done");
    cmd(8'd33, on_delay_mode, 1'b1, 1'b0, 1'b0, 16'h0001);
    idle(60);
    sc(8'd33, 17'h0);
    bus(1'b1, 8'h00, 32'h1);
    st(8'd33);
    v = q[16:0];
    check({31'h0, v[16]}, 32'h1);
    idle(60);
    sc(8'd33, v);
    $display("test scan done");
    wrap_up();
  end
endmodule

bind plc_timer_bank plc_timer_bank_properties u_plc_timer_bank_properties (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_bits_o(timer_bits_o));
`default_nettype wire
